// [hdl/itm_pkg.sv]
// itm_pkg: shared constants and types for the two-wire master engine
// assumes: included before the line interface and both engine modules
package itm_pkg;

  // ==========================================================================
  // widths
  localparam int PER_W  = 8;   // period and hold programming width
  localparam int ADDR_W = 7;   // own slave address width
  localparam int BYTE_W = 8;   // shifted byte width

  // ==========================================================================
  // mode select and bit counting
  localparam logic [1:0] MODE_TWOWIRE = 2'h3;  // unit_mode_select code for two-wire
  localparam logic [3:0] BIT_FIRST    = 4'h0;  // first bit of a byte (msb)
  localparam logic [3:0] BIT_ACK      = 4'h8;  // ninth bit: acknowledge slot
  localparam logic [PER_W:0] CNT_ONE  = 9'h001;
  localparam logic [PER_W:0] CNT_ZERO = 9'h000;
  localparam logic [PER_W:0] CNT_MAX  = 9'h1ff;

  // ==========================================================================
  // values after reset
  localparam logic [BYTE_W-1:0] DATA_RST = 8'h00;
  localparam logic [3:0]        BIT_RST  = 4'h0;
  localparam logic [2:0]        SYNC_RST = 3'h7;  // idle bus reads high

  // ==========================================================================
  // engine states, one-hot
  typedef enum logic [10:0] {
    ST_IDLE      = 11'h001,
    ST_START     = 11'h002,
    ST_BIT_LOW   = 11'h004,
    ST_BIT_HIGH  = 11'h008,
    ST_HOLD      = 11'h010,
    ST_RS_LOW    = 11'h020,
    ST_RS_HIGH   = 11'h040,
    ST_STOP_LOW  = 11'h080,
    ST_STOP_HIGH = 11'h100,
    ST_STOP_END  = 11'h200,
    ST_DONE      = 11'h400
  } itm_state_t;

endpackage : itm_pkg

// [hdl/itm_line_if.sv]
// itm_line_if: filtered bus levels and bus conditions between the
// pin synchroniser and the engine
// assumes: one clk_sys domain on both sides
`timescale 1ns/1ps
interface itm_line_if;
  logic scl_lvl;     // filtered clock line level
  logic sda_lvl;     // filtered data line level
  logic start_seen;  // start condition seen, one cycle
  logic stop_seen;   // stop condition seen, one cycle

  modport src (output scl_lvl, output sda_lvl, output start_seen, output stop_seen);
  modport snk (input scl_lvl, input sda_lvl, input start_seen, input stop_seen);
endinterface : itm_line_if

// [hdl/itm_pin_sync.sv]
// itm_pin_sync: three-flop synchroniser and agreement filter for the two
// bus lines, plus start and stop detection on the filtered levels
// assumes: raw pin levels are asynchronous to clk_sys
`timescale 1ns/1ps
module itm_pin_sync (
  input  wire logic  clk_sys,  // system clock
  input  wire logic  rst_b,    // sync reset, active low
  input  wire logic  scl_i,    // raw clock line level
  input  wire logic  sda_i,    // raw data line level
  itm_line_if.src    line      // filtered levels out
);
  import itm_pkg::*;

  logic [1:0] raw;
  logic [1:0] lvl_r;
  logic [1:0] lvl_d_r;

  assign raw = {scl_i, sda_i};

  // ==========================================================================
  // per line: three flops, level moves when second and third agree
  for (genvar g = 0; g < 2; g++) begin : g_line
    logic [2:0] sync_r;
    always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
        sync_r <= SYNC_RST;
      end else begin
        sync_r <= {sync_r[1:0], raw[g]};
      end
    end
    always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
        lvl_r[g] <= 1'b1;
      end else if (sync_r[1] == sync_r[2]) begin
        lvl_r[g] <= sync_r[1];
      end
    end
  end

  // ==========================================================================
  // previous filtered level for condition detection
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      lvl_d_r <= 2'h3;
    end else begin
      lvl_d_r <= lvl_r;
    end
  end

  // data edges while the clock line stays high
  assign line.scl_lvl    = lvl_r[1];
  assign line.sda_lvl    = lvl_r[0];
  assign line.start_seen = lvl_r[1] & lvl_d_r[1] & lvl_d_r[0] & ~lvl_r[0];
  assign line.stop_seen  = lvl_r[1] & lvl_d_r[1] & ~lvl_d_r[0] & lvl_r[0];

endmodule : itm_pin_sync

// [hdl/itm_engine.sv]
// itm_engine: two-wire bus master engine, transmitter and receiver roles
// assumes: open-drain pads outside; oe high pulls the line low; software
// side reaches the control and status bits as plain ports
`timescale 1ns/1ps

module itm_engine (
  input  wire logic                         clk_sys,             // system clock
  input  wire logic                         rst_b,               // sync reset, active low
  input  wire logic [1:0]                   unit_mode_select,    // mode select field
  input  wire logic                         unit_enable_bit,     // unit enable
  input  wire logic                         shift_data_wr,       // data register write strobe
  input  wire logic [itm_pkg::BYTE_W-1:0]   shift_data_in,       // data register write value
  input  wire logic [itm_pkg::PER_W-1:0]    clk_low_period_reg,  // clock low period
  input  wire logic [itm_pkg::PER_W-1:0]    clk_high_period_reg, // clock high period
  input  wire logic [itm_pkg::PER_W-1:0]    sda_hold_reg,        // data hold after fall
  input  wire logic [itm_pkg::ADDR_W-1:0]   own_slave_addr_field,// own slave address
  input  wire logic                         start_cmd_bit,       // start command strobe
  input  wire logic                         stop_cmd_bit,        // stop command strobe
  input  wire logic                         ack_enable_bit,      // acknowledge enable level
  input  wire logic                         bus_state_wr,        // status write strobe
  input  wire logic                         scl_i,               // clock line level
  input  wire logic                         sda_i,               // data line level
  output logic                              scl_o,               // clock line out, always 0
  output logic                              scl_oe,              // clock line pull low
  output logic                              sda_o,               // data line out, always 0
  output logic                              sda_oe,              // data line pull low
  output logic [itm_pkg::BYTE_W-1:0]        shift_data_reg,      // data register read value
  output logic                              arb_lost_flag,       // mastership lost
  output logic                              rx_ack_flag,         // acknowledge seen
  output logic                              stop_done_flag,      // stop finished
  output logic                              address_phase_irq,   // address byte done
  output logic                              byte_done_irq,       // data byte done
  output logic                              twowire_irq_flag,    // any bus event
  output logic                              master_rx_role,      // 1 receiver, 0 transmitter
  output logic                              slave_sel_flag,      // addressed as slave
  output logic                              bus_busy_flag        // bus between start and stop
);
  import itm_pkg::*;

  itm_line_if line ();

  itm_state_t          state_r;
  itm_state_t          state_nxt;
  logic [PER_W:0]      cnt_r;
  logic [3:0]          bit_idx_r;
  logic [BYTE_W-1:0]   sh_r;
  logic                start_pend_r;
  logic                stop_pend_r;
  logic                addr_ph_r;
  logic                ena;
  logic                lo_done;
  logic                hi_done;
  logic                hold_hit;
  logic                scl_rel;
  logic                tx_now;
  logic                arb_hit;
  logic                ack_end;
  logic                match;
  logic                drv_bit;

  // ==========================================================================
  // pin synchroniser
  itm_pin_sync u_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .line    (line)
  );

  // ==========================================================================
  // phase timing and decode
  assign ena      = unit_enable_bit && (unit_mode_select == MODE_TWOWIRE);
  assign lo_done  = (cnt_r + CNT_ONE) >= {1'b0, clk_low_period_reg};
  assign hi_done  = line.scl_lvl && ((cnt_r + CNT_ONE) >= {1'b0, clk_high_period_reg});
  assign hold_hit = cnt_r == {1'b0, sda_hold_reg};
  assign scl_rel  = (state_r == ST_START) || (state_r == ST_BIT_HIGH) ||
                    (state_r == ST_RS_HIGH) || (state_r == ST_STOP_HIGH) ||
                    (state_r == ST_STOP_END);
  assign tx_now   = (addr_ph_r || !master_rx_role) && !arb_lost_flag;
  assign match    = sh_r[BYTE_W-1:1] == own_slave_addr_field;
  assign ack_end  = (state_r == ST_BIT_HIGH) && hi_done && (bit_idx_r == BIT_ACK);

  // released data while sending a one but bus reads low
  assign arb_hit  = (state_r == ST_BIT_HIGH) && (bit_idx_r < BIT_ACK) && tx_now &&
                    !sda_oe && line.scl_lvl && !line.sda_lvl;

  // ==========================================================================
  // level to drive in a bit slot
  always_comb begin
    if (bit_idx_r < BIT_ACK) begin
      drv_bit = tx_now && !sh_r[BYTE_W-1];
    end else if (arb_lost_flag) begin
      drv_bit = ack_enable_bit && match;
    end else begin
      drv_bit = master_rx_role && !addr_ph_r && ack_enable_bit;
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_pend_r && !bus_busy_flag) begin
          state_nxt = ST_START;
        end
      end
      ST_START: begin
        if (hi_done) begin
          state_nxt = ST_BIT_LOW;
        end
      end
      ST_BIT_LOW: begin
        if (lo_done) begin
          state_nxt = ST_BIT_HIGH;
        end
      end
      ST_BIT_HIGH: begin
        if (arb_hit && !addr_ph_r) begin
          state_nxt = ST_IDLE;
        end else if (ack_end) begin
          if (arb_lost_flag && !(ack_enable_bit && match)) begin
            state_nxt = ST_IDLE;
          end else begin
            state_nxt = ST_HOLD;
          end
        end else if (hi_done) begin
          state_nxt = ST_BIT_LOW;
        end
      end
      ST_HOLD: begin
        if (bus_state_wr) begin
          if (slave_sel_flag) begin
            state_nxt = ST_IDLE;
          end else if (stop_pend_r) begin
            state_nxt = ST_STOP_LOW;
          end else if (start_pend_r) begin
            state_nxt = ST_RS_LOW;
          end else begin
            state_nxt = ST_BIT_LOW;
          end
        end
      end
      ST_RS_LOW: begin
        if (lo_done) begin
          state_nxt = ST_RS_HIGH;
        end
      end
      ST_RS_HIGH: begin
        if (hi_done) begin
          state_nxt = ST_START;
        end
      end
      ST_STOP_LOW: begin
        if (lo_done) begin
          state_nxt = ST_STOP_HIGH;
        end
      end
      ST_STOP_HIGH: begin
        if (hi_done) begin
          state_nxt = ST_STOP_END;
        end
      end
      ST_STOP_END: begin
        if (hi_done) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        if (bus_state_wr) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (!ena) begin
      state_nxt = ST_IDLE;
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // phase counter; waits while another party stretches the clock
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_r <= CNT_ZERO;
    end else if (state_nxt != state_r) begin
      cnt_r <= CNT_ZERO;
    end else if (scl_rel && !line.scl_lvl) begin
      cnt_r <= CNT_ZERO;
    end else if (cnt_r != CNT_MAX) begin
      cnt_r <= cnt_r + CNT_ONE;
    end
  end

  // ==========================================================================
  // bit index and shifter
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      bit_idx_r <= BIT_RST;
      sh_r      <= DATA_RST;
    end else if ((state_nxt == ST_BIT_LOW) &&
                 ((state_r == ST_START) || (state_r == ST_HOLD))) begin
      bit_idx_r <= BIT_FIRST;
      sh_r      <= shift_data_reg;
    end else if ((state_r == ST_BIT_HIGH) && hi_done && (bit_idx_r < BIT_ACK)) begin
      bit_idx_r <= bit_idx_r + 4'h1;
      sh_r      <= {sh_r[BYTE_W-2:0], line.sda_lvl};
    end
  end

  // data register: software write, or a byte taken from the slave
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      shift_data_reg <= DATA_RST;
    end else if (shift_data_wr) begin
      shift_data_reg <= shift_data_in;
    end else if (ack_end && master_rx_role && !addr_ph_r && !arb_lost_flag) begin
      shift_data_reg <= sh_r;
    end
  end

  // ==========================================================================
  // pending commands and address phase
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      start_pend_r <= 1'b0;
      stop_pend_r  <= 1'b0;
      addr_ph_r    <= 1'b0;
    end else if (!ena) begin
      start_pend_r <= 1'b0;
      stop_pend_r  <= 1'b0;
      addr_ph_r    <= 1'b0;
    end else begin
      if (start_cmd_bit) begin
        start_pend_r <= 1'b1;
      end else if (state_nxt == ST_START) begin
        start_pend_r <= 1'b0;
      end
      if (stop_cmd_bit) begin
        stop_pend_r <= 1'b1;
      end else if (state_nxt == ST_STOP_LOW) begin
        stop_pend_r <= 1'b0;
      end
      if (state_nxt == ST_START) begin
        addr_ph_r <= 1'b1;
      end else if (ack_end || (state_nxt == ST_IDLE)) begin
        addr_ph_r <= 1'b0;
      end
    end
  end

  // role from the direction bit of the address just sent
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      master_rx_role <= 1'b0;
    end else if (ack_end && addr_ph_r && !arb_lost_flag) begin
      master_rx_role <= shift_data_reg[0];
    end
  end

  // ==========================================================================
  // status flags; a set wins over a status write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      arb_lost_flag     <= 1'b0;
      rx_ack_flag       <= 1'b0;
      stop_done_flag    <= 1'b0;
      address_phase_irq <= 1'b0;
      byte_done_irq     <= 1'b0;
      slave_sel_flag    <= 1'b0;
    end else begin
      if (arb_hit) begin
        arb_lost_flag <= 1'b1;
      end else if (bus_state_wr || (state_nxt == ST_START)) begin
        arb_lost_flag <= 1'b0;
      end
      if (ack_end) begin
        rx_ack_flag <= !line.sda_lvl;
      end
      if ((state_r == ST_STOP_END) && (state_nxt == ST_DONE)) begin
        stop_done_flag <= 1'b1;
      end else if (bus_state_wr) begin
        stop_done_flag <= 1'b0;
      end
      if (ack_end && addr_ph_r && !arb_lost_flag) begin
        address_phase_irq <= 1'b1;
      end else if (bus_state_wr) begin
        address_phase_irq <= 1'b0;
      end
      if (ack_end && !addr_ph_r && !arb_lost_flag) begin
        byte_done_irq <= 1'b1;
      end else if (bus_state_wr) begin
        byte_done_irq <= 1'b0;
      end
      if (ack_end && arb_lost_flag && ack_enable_bit && match) begin
        slave_sel_flag <= 1'b1;
      end else if (bus_state_wr) begin
        slave_sel_flag <= 1'b0;
      end
    end
  end

  // shared interrupt flag; start transmission is not an event
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      twowire_irq_flag <= 1'b0;
    end else if ((ack_end && (state_nxt == ST_HOLD)) || arb_hit ||
                 ((state_r == ST_STOP_END) && (state_nxt == ST_DONE))) begin
      twowire_irq_flag <= 1'b1;
    end else if (bus_state_wr) begin
      twowire_irq_flag <= 1'b0;
    end
  end

  // bus busy between start and stop seen on the lines
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      bus_busy_flag <= 1'b0;
    end else if (line.start_seen) begin
      bus_busy_flag <= 1'b1;
    end else if (line.stop_seen) begin
      bus_busy_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // line drivers: pull low or release only
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      scl_o  <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      scl_o  <= 1'b0;
      scl_oe <= (state_nxt == ST_BIT_LOW) || (state_nxt == ST_HOLD) ||
                (state_nxt == ST_RS_LOW) || (state_nxt == ST_STOP_LOW);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sda_o  <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      case (state_r)
        ST_START, ST_STOP_HIGH: begin
          sda_oe <= 1'b1;
        end
        ST_BIT_LOW: begin
          if (hold_hit) begin
            sda_oe <= drv_bit;
          end
        end
        ST_BIT_HIGH: begin
          if (arb_hit || (state_nxt == ST_IDLE)) begin
            sda_oe <= 1'b0;
          end
        end
        ST_RS_LOW: begin
          if (hold_hit) begin
            sda_oe <= 1'b0;
          end
        end
        ST_STOP_LOW: begin
          if (hold_hit) begin
            sda_oe <= 1'b1;
          end
        end
        ST_HOLD: begin
          sda_oe <= sda_oe;
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule : itm_engine

// [test/itm_engine_monitor.sv]
// itm_engine_monitor: port timing checks for the two-wire engine
// assumes: bound into itm_engine, one clk_sys domain
`timescale 1ns/1ps
module itm_engine_monitor (
  input wire logic                      clk_sys,            // clock
  input wire logic                      rst_b,              // reset
  input wire logic                      bus_state_wr,       // status write
  input wire logic [itm_pkg::PER_W-1:0] clk_low_period_reg, // low period
  input wire logic [itm_pkg::PER_W-1:0] sda_hold_reg,       // data hold
  input wire logic                      scl_o,              // clock out
  input wire logic                      scl_oe,             // clock pull
  input wire logic                      sda_o,              // data out
  input wire logic                      sda_oe,             // data pull
  input wire logic                      arb_lost_flag,      // lost
  input wire logic                      stop_done_flag,     // stop done
  input wire logic                      address_phase_irq,  // address done
  input wire logic                      byte_done_irq,      // byte done
  input wire logic                      twowire_irq_flag    // event flag
);
  import itm_pkg::*;
  // ==========================================================================
  // cycles the clock line has been pulled low; a status write restarts the phase
  logic [PER_W:0] low_cnt_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !scl_oe || bus_state_wr) low_cnt_r <= CNT_ZERO;
    else if (low_cnt_r != CNT_MAX) low_cnt_r <= low_cnt_r + CNT_ONE;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // checks
  property p_pull_only; !scl_o && !sda_o; endproperty
  a_pull_only: assert property (p_pull_only) else $error("line driven high");
  property p_hold_low;
    (address_phase_irq || byte_done_irq) && !arb_lost_flag && !$past(bus_state_wr) |-> scl_oe;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("clock not held");
  property p_flag_clear; bus_state_wr && twowire_irq_flag |=> !twowire_irq_flag; endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag kept");
  property p_flag_stand; twowire_irq_flag && !bus_state_wr |=> twowire_irq_flag; endproperty
  a_flag_stand: assert property (p_flag_stand) else $error("flag dropped");
  property p_addr_irq; $rose(address_phase_irq) |-> twowire_irq_flag && scl_oe; endproperty
  a_addr_irq: assert property (p_addr_irq) else $error("address event wrong");
  property p_byte_irq;
    $rose(byte_done_irq) |-> twowire_irq_flag && scl_oe && !arb_lost_flag;
  endproperty
  a_byte_irq: assert property (p_byte_irq) else $error("byte event wrong");
  property p_stop_done; $rose(stop_done_flag) |-> twowire_irq_flag && !scl_oe && !sda_oe; endproperty
  a_stop_done: assert property (p_stop_done) else $error("stop event wrong");
  property p_data_hold;
    scl_oe && $changed(sda_oe) && low_cnt_r <= {1'b0, clk_low_period_reg}
      |-> low_cnt_r == {1'b0, sda_hold_reg} + CNT_ONE;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved off hold");
  // main scenarios reached
  c_addr: cover property ($rose(address_phase_irq));
  c_byte: cover property ($rose(byte_done_irq));
  c_stop: cover property ($rose(stop_done_flag));
endmodule : itm_engine_monitor
bind itm_engine itm_engine_monitor mon_u (.*);

// [test/itm_slave_model.sv]
// itm_slave_model: behavioural bus slave that acks, sends, stretches or fights
// assumes: lines resolved outside with pull-ups, pulls active high
`timescale 1ns/1ps
module itm_slave_model (
  input  wire logic       scl,      // clock line
  input  wire logic       sda,      // data line
  input  wire logic       nack,     // refuse acks, fight addresses too
  input  wire logic       fight,    // pull data low on written bytes
  input  wire logic       stretch,  // hold clock low a while
  input  wire logic [7:0] tx_byte,  // byte to send
  output logic            sda_pull, // data pull low
  output logic            scl_pull, // clock pull low
  output logic [7:0]      rx_byte,  // byte seen
  output logic            ack_seen  // ack seen in ninth bit
);
  int   n = 0;
  logic adr = 1'b0, rd = 1'b0;
  initial {sda_pull, scl_pull, ack_seen, rx_byte} = 11'h000;
  // start or stop restarts the byte framing
  always @(sda) begin
    if (scl === 1'b1) begin
      n = 0;
      adr = !sda;
      rd = 1'b0;
    end
  end
  // sample bits, direction from the address, quit sending on a refusal
  always @(posedge scl) begin
    if (n < 8) rx_byte = {rx_byte[6:0], sda};
    else ack_seen = !sda;
    if (n == 8 && adr) rd = rx_byte[0];
    else if (n == 8 && sda) rd = 1'b0;
    if (n == 8) adr = 1'b0;
    n = (n == 8) ? 0 : n + 1;
  end
  // drive ack, read data or a fight just after the clock falls
  always @(negedge scl) begin
    if (n == 8) sda_pull = (adr || !rd) && !nack;
    else if (rd && !adr) sda_pull = !tx_byte[7 - n];
    else sda_pull = fight && (!adr || nack);
  end
  // read data follows a byte loaded while the clock is held low
  always @(tx_byte) if (rd && !adr && n < 8) sda_pull = !tx_byte[7 - n];
  // slow partner: keep the clock low after each fall
  always @(negedge scl) begin
    if (stretch) begin
      scl_pull = 1'b1;
      #200 scl_pull = 1'b0;
    end
  end
  always @(negedge fight) sda_pull = 1'b0;
endmodule : itm_slave_model

// [test/itm_engine_bench.sv]
// itm_engine_bench: engine against a slave model, sent bytes checked by a queue model
// assumes: pulled-up lines, the slave model is the only other party
`timescale 1ns/1ps
module itm_engine_bench;
  import itm_pkg::*;
  logic        clk_sys, rst_b, unit_enable_bit, shift_data_wr, start_cmd_bit, stop_cmd_bit;
  logic        ack_enable_bit, bus_state_wr, nack, fight, stretch, scl_o, scl_oe, sda_o, sda_oe;
  logic        arb_lost_flag, rx_ack_flag, stop_done_flag, address_phase_irq, byte_done_irq;
  logic        twowire_irq_flag, master_rx_role, slave_sel_flag, bus_busy_flag, s_pull, c_pull;
  logic        p_ack;
  logic [1:0]  unit_mode_select;
  logic [6:0]  own_slave_addr_field, adr;
  logic [7:0]  shift_data_in, clk_low_period_reg, clk_high_period_reg, sda_hold_reg;
  logic [7:0]  shift_data_reg, tx_b, rx_b;
  logic [31:0] seed;
  int          fails = 0, comparisons = 0, cyc = 0, q[$];
  wire         scl_i = !scl_oe && !c_pull;  // wired-and with pull-up
  wire         sda_i = !sda_oe && !s_pull;
  itm_engine dut_u (.*);
  itm_slave_model slv_u (.scl(scl_i), .sda(sda_i), .nack, .fight, .stretch, .tx_byte(tx_b),
                         .sda_pull(s_pull), .scl_pull(c_pull), .rx_byte(rx_b), .ack_seen(p_ack));
  // ==========================================================================
  // clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  // ==========================================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // strobes {write, start, stop, status write} for one cycle
  task automatic step(input logic [3:0] c);
    {shift_data_wr, start_cmd_bit, stop_cmd_bit, bus_state_wr} = c;
    @(negedge clk_sys);
    {shift_data_wr, start_cmd_bit, stop_cmd_bit, bus_state_wr} = 4'h0;
    @(negedge clk_sys);
  endtask : step
  task automatic wait_irq();
    int n;
    n = 0;
    while (twowire_irq_flag !== 1'b1 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 3000) fails++;  // a lost event counts as a mismatch
  endtask : wait_irq
  // load a byte; c: 0 continue, 1 start from idle, 2 repeated start
  task automatic send(input logic [7:0] b, input int c);
    q.push_back(int'(b));
    shift_data_in = b;
    step(4'h8);
    if (c != 0) step(4'h4);
    if (c != 1) step(4'h1);
    wait_irq();
    chk(rx_b, 8'(q.pop_front()));
  endtask : send
  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // ==========================================================================
  // main sequence
  initial begin
    {rst_b, shift_data_wr, start_cmd_bit, stop_cmd_bit, bus_state_wr} = 5'h00;
    {ack_enable_bit, nack, fight, stretch, shift_data_in, tx_b} = 20'h00000;
    unit_mode_select = MODE_TWOWIRE;
    unit_enable_bit = 1'b1;
    seed = lfsr(32'h2ea7);
    clk_low_period_reg = 8'h08 + {5'h00, seed[2:0]};
    clk_high_period_reg = 8'h06 + {5'h00, seed[5:3]};
    sda_hold_reg = clk_low_period_reg >> 1;
    adr = seed[14:8];
    own_slave_addr_field = ~adr;
    repeat (12) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    send({adr, 1'b0}, 1);
    chk({6'h00, address_phase_irq, rx_ack_flag}, 8'h03);
    // two written bytes, the second refused by a slow slave
    for (int i = 0; i < 2; i++) begin
      {nack, stretch} = {i[0], i[0]};
      seed = lfsr(seed);
      send(seed[7:0], 0);
      chk({6'h00, byte_done_irq, scl_oe}, 8'h03);
      chk({7'h00, rx_ack_flag}, {7'h00, !nack});
    end
    nack = 1'b0;
    send({adr, 1'b1}, 2);
    chk({6'h00, master_rx_role, address_phase_irq}, 8'h03);
    // two read bytes, acked then not
    for (int i = 0; i < 2; i++) begin
      ack_enable_bit = !i[0];
      seed = lfsr(seed);
      tx_b = seed[7:0];
      step(4'h1);
      wait_irq();
      chk(shift_data_reg, tx_b);
      chk({6'h00, byte_done_irq, p_ack}, {6'h00, 1'b1, ack_enable_bit});
    end
    step(4'h2);
    step(4'h1);
    wait_irq();
    chk({6'h00, stop_done_flag, scl_oe}, 8'h02);
    step(4'h1);
    chk({6'h00, twowire_irq_flag, stop_done_flag}, 8'h00);
    // lose the bus on a data byte the slave fights over
    send({adr, 1'b0}, 1);
    fight = 1'b1;
    shift_data_in = 8'hff;
    step(4'h8);
    step(4'h1);
    wait_irq();
    chk({5'h00, arb_lost_flag, byte_done_irq, scl_oe}, 8'h04);
    fight = 1'b0;
    // lose the address to a rival, then be picked as slave by own address
    own_slave_addr_field = 7'h00;
    ack_enable_bit = 1'b1;
    shift_data_in = {adr, 1'b0};
    step(4'h8);
    {nack, fight} = 2'h3;
    step(4'h4);
    repeat (600) @(negedge clk_sys);
    chk({4'h0, arb_lost_flag, slave_sel_flag, address_phase_irq, scl_oe}, 8'h0d);
    report_and_stop();
  end
endmodule : itm_engine_bench
